// ### purs_defines.svh
// constants for the power-up reset sequencer
`ifndef PURS_DEFINES_SVH
`define PURS_DEFINES_SVH

// ****************************************
// clock and timing
// ****************************************
`define PURS_CLK_KHZ        50000
`define PURS_CLK_PERIOD_NS  20
`define PURS_RC_KHZ         1000
`define PURS_STARTUP_MS     72
`define PURS_OST_CYCLES     1024
`define PURS_FILTER_NS      200
`define PURS_RC_DIV         (`PURS_CLK_KHZ / `PURS_RC_KHZ)
`define PURS_STARTUP_TICKS  (`PURS_STARTUP_MS * `PURS_RC_KHZ)
`define PURS_FILTER_CYCLES  ((`PURS_FILTER_NS + `PURS_CLK_PERIOD_NS - 1) / `PURS_CLK_PERIOD_NS)

// ****************************************
// register map
// ****************************************
`define PURS_ADDR_PWR_CTRL   8'h8E
`define PURS_ADDR_RST_FLAGS  8'h8F
`define PURS_BIT_POR_FLAG    1
`define PURS_BIT_TIMEOUT     0
`define PURS_BIT_POWERDOWN   1
`define PURS_PWR_CTRL_RESET  8'h00

// ****************************************
// program counter vectors
// ****************************************
`define PURS_PC_W            13
`define PURS_PC_RESET_VEC    13'h0000
`define PURS_PC_IRQ_VEC      13'h0004

// ****************************************
// status outcomes: value and load mask
// ****************************************
`define PURS_ST_POR_VAL      8'h18
`define PURS_ST_POR_MSK      8'hF8
`define PURS_ST_EXT_VAL      8'h00
`define PURS_ST_EXT_MSK      8'hE0
`define PURS_ST_EXTSL_VAL    8'h10
`define PURS_ST_EXTSL_MSK    8'hF8
`define PURS_ST_WDT_VAL      8'h00
`define PURS_ST_WDT_MSK      8'hF0
`define PURS_ST_WDTWK_VAL    8'h00
`define PURS_ST_WDTWK_MSK    8'h18
`define PURS_ST_IRQWK_VAL    8'h10
`define PURS_ST_IRQWK_MSK    8'h18

// ****************************************
// wake source bits
// ****************************************
`define PURS_SRC_ADC         3

`endif

// ### purs_pin_model.sv
// supply, reset pin and crystal model outside the sequencer
`timescale 1ns/100ps

module purs_pin_model (
  // supply and pins
  output logic supply_ok,
  output logic external_reset_n,
  output logic osc_input_pin
);
  logic pin_rel;

  // the pin is only let go while the supply is good, so no early exit
  assign external_reset_n = pin_rel & supply_ok;

  // free-running crystal, phase unrelated to clk
  initial begin
    supply_ok     = 1'b0;
    pin_rel       = 1'b1;
    osc_input_pin = 1'b0;
    forever #35 osc_input_pin = ~osc_input_pin;
  end

  task automatic power(input logic on);
    supply_ok <= on;
  endtask

  task automatic pin(input logic rel);
    pin_rel <= rel;
  endtask
endmodule // purs_pin_model

// ### purs_pkg.sv
// types for the power-up reset sequencer
package purs_pkg;

  typedef enum logic [2:0] {
    PURS_LOW_POWER_CRYSTAL,
    PURS_STANDARD_CRYSTAL,
    PURS_FAST_CRYSTAL,
    PURS_INTERNAL_RC,
    PURS_EXTERNAL_RC
  } purs_osc_mode_t;

  typedef enum logic [2:0] {
    PURS_S_POR,
    PURS_S_STARTUP_DELAY_TIMER,
    PURS_S_OST,
    PURS_S_RELEASE,
    PURS_S_RUN
  } purs_state_t;

endpackage

// ### purs_rst_filter.sv
// synchroniser and glitch filter for the external reset pin
`timescale 1ns/100ps
`include "purs_defines.svh"

module purs_rst_filter #(
  parameter int FILT_CYCLES = `PURS_FILTER_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and result
  input  wire logic pin_n,
  output logic      filtered_n
);

  logic       sync1_r;
  logic       sync2_r;
  logic [7:0] cnt_r;
  logic       differ;
  logic       settle;

  assign differ = sync2_r != filtered_n;
  assign settle = differ && (cnt_r == 8'(FILT_CYCLES - 1));

  // a new level must hold for the whole window before it is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r    <= 1'b0;
      sync2_r    <= 1'b0;
      cnt_r      <= 8'h00;
      filtered_n <= 1'b0;
    end else begin
      sync1_r <= pin_n;
      sync2_r <= sync1_r;
      cnt_r   <= (differ && !settle) ? cnt_r + 8'h01 : 8'h00;
      if (settle) begin
        filtered_n <= sync2_r;
      end
    end
  end

  property p_filt_stable;
    @(posedge clk) disable iff (rst)
      (filtered_n != $past(filtered_n)) |-> $past(cnt_r) == 8'(FILT_CYCLES - 1);
  endproperty
  a_filt_stable: assert property (p_filt_stable) else $error("reset filter passed a short pulse");

endmodule // purs_rst_filter

// ### purs_seq.sv
// power-up reset sequencer: start-up timing, reset causes and outcomes
//
// Contract
// - hold the chip in reset until the supply is judged sufficient
// - start-up delay of 72 ms, only after power-on, never other resets
// - start-up delay runs on its own rc tick; reset held meanwhile
// - start-up delay applied when enable_n is 0, skipped when 1
// - after the start-up delay, hold a further 1024 oscillator pin cycles
// - stabilise count only in crystal modes, on power-on or wake
// - power-on detector, then start-up delay, then stabilise count
// - rc modes skip the stabilise count; both off means no time-out
// - time-outs ignore the reset pin; release follows pin going high
// - power-on flag bit 1 at 8Eh clears on power-on only; software sets
// - reset-cause flags per power-on, watchdog reset, watchdog wake, pin reset
// - pin reset in sleep or irq wake: timeout 1, powerdown 0
// - resets load pc 000h; wake goes pc+1, irq with enable 0004h
// - status outcomes 0001 1xxx, 0000 uuuu, uuu1 0uuu
// - converter wake sets peripheral bit 6, clears converter bit 3
// - any wake updates the flag bits of its source; only an irq wake sets source flag bits here, a watchdog wake sets none
// - a watchdog reset acts inside only, never pulls the pin
// - short glitches on the reset pin are filtered out
`timescale 1ns/100ps
`include "purs_defines.svh"

module purs_seq import purs_pkg::*; #(
  parameter int STARTUP_TICKS = `PURS_STARTUP_TICKS,
  parameter int RC_DIV        = `PURS_RC_DIV,
  parameter int OST_CYCLES    = `PURS_OST_CYCLES
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            rst,
  // supply and pins
  input  wire logic            supply_ok,
  input  wire logic            external_reset_n,
  input  wire logic            osc_input_pin,
  // configuration
  input  wire logic            startup_delay_enable_n,
  input  purs_osc_mode_t       osc_mode,
  // core events
  input  wire logic            sleep_active,
  input  wire logic            wdt_expire,
  input  wire logic            wake_irq,
  input  wire logic [3:0]      irq_wake_src,
  input  wire logic            global_irq_enable,
  // register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output logic [7:0]           reg_rdata,
  // core control
  output logic                 core_reset,
  output logic                 core_hold,
  output logic                 pc_load,
  output logic [`PURS_PC_W-1:0] pc_vector,
  output logic                 pc_advance,
  output logic                 status_load,
  output logic [7:0]           status_value,
  output logic [7:0]           status_mask,
  output logic [2:0]           irq_ctrl_flag_set,
  output logic                 periph_flag_set,
  output logic                 converter_go_clear,
  // reset-cause flags
  output logic                 timeout_flag,
  output logic                 powerdown_flag,
  output logic                 power_on_flag
);

  // ****************************************
  // pin synchronisers and counters
  // ****************************************
  purs_state_t state_r, state_nxt;
  logic        sup1_r, sup2_r, osc_input_pin_r, osc2_r, osc3_r;
  logic        ext_ok;
  logic [7:0]  rc_div_r;
  logic [16:0] startup_delay_timer_cnt_r;
  logic [10:0] ost_cnt_r;
  logic        wake_ost_r, wake_ost_nxt;
  logic        rc_tick, osc_edge, startup_delay_timer_done, ost_done, crystal;

  purs_rst_filter u_filter (
    .clk        (clk),
    .rst        (rst),
    .pin_n      (external_reset_n),
    .filtered_n (ext_ok)
  );

  assign crystal   = (osc_mode == PURS_LOW_POWER_CRYSTAL) || (osc_mode == PURS_STANDARD_CRYSTAL) ||
                     (osc_mode == PURS_FAST_CRYSTAL);
  assign rc_tick   = rc_div_r == 8'(RC_DIV - 1);
  assign osc_edge  = osc2_r && !osc3_r;
  assign startup_delay_timer_done = rc_tick && (startup_delay_timer_cnt_r == 17'(STARTUP_TICKS - 1));
  assign ost_done  = osc_edge && (ost_cnt_r == 11'(OST_CYCLES - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sup1_r <= 1'b0;
      sup2_r <= 1'b0;
      osc_input_pin_r <= 1'b0;
      osc2_r <= 1'b0;
      osc3_r <= 1'b0;
    end else begin
      sup1_r <= supply_ok;
      sup2_r <= sup1_r;
      osc_input_pin_r <= osc_input_pin;
      osc2_r <= osc_input_pin_r;
      osc3_r <= osc2_r;
    end
  end

  // the rc divider stands in for the private start-up oscillator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rc_div_r   <= 8'h00;
      startup_delay_timer_cnt_r <= 17'h00000;
      ost_cnt_r  <= 11'h000;
    end else begin
      rc_div_r   <= (state_r != PURS_S_STARTUP_DELAY_TIMER || rc_tick) ? 8'h00 : rc_div_r + 8'h01;
      startup_delay_timer_cnt_r <= (state_r != PURS_S_STARTUP_DELAY_TIMER) ? 17'h00000 : startup_delay_timer_cnt_r + {16'h0000, rc_tick};
      ost_cnt_r  <= (state_r != PURS_S_OST) ? 11'h000 : ost_cnt_r + {10'h000, osc_edge};
    end
  end

  // ****************************************
  // sequencer and event outcomes
  // ****************************************
  logic       por_evt, ext_evt, wdt_rst_evt, wdt_wake_evt, irq_wake_evt;
  logic       in_run, ext_low;
  logic       to_set, to_clr, pd_set, pd_clr;
  logic       pc_load_nxt, pc_adv_nxt, st_load_nxt;
  logic [`PURS_PC_W-1:0] pc_vec_nxt;
  logic [7:0] st_val_nxt, st_msk_nxt;

  assign in_run       = state_r == PURS_S_RUN;
  assign ext_low      = !ext_ok;
  assign por_evt      = (state_r == PURS_S_POR) && sup2_r;
  assign ext_evt      = sup2_r && in_run && ext_low;
  assign wdt_rst_evt  = sup2_r && in_run && !ext_low && wdt_expire && !sleep_active;
  assign wdt_wake_evt = sup2_r && in_run && !ext_low && wdt_expire && sleep_active;
  assign irq_wake_evt = sup2_r && in_run && !ext_low && !wdt_expire && wake_irq && sleep_active;

  assign to_set = por_evt || (ext_evt && sleep_active) || irq_wake_evt;
  assign to_clr = wdt_rst_evt || wdt_wake_evt;
  assign pd_set = por_evt;
  assign pd_clr = (ext_evt && sleep_active) || irq_wake_evt || wdt_wake_evt;
  assign wake_ost_nxt = (wdt_wake_evt || irq_wake_evt) ? 1'b1 : (por_evt ? 1'b0 : wake_ost_r);

  always_comb begin
    state_nxt   = state_r;
    pc_load_nxt = 1'b0;
    pc_adv_nxt  = 1'b0;
    pc_vec_nxt  = `PURS_PC_RESET_VEC;
    st_load_nxt = 1'b1;
    st_val_nxt  = 8'h00;
    st_msk_nxt  = 8'h00;
    if (!sup2_r) begin
      state_nxt   = PURS_S_POR;
      st_load_nxt = 1'b0;
    end else if (por_evt) begin
      if (!startup_delay_enable_n) begin
        state_nxt = PURS_S_STARTUP_DELAY_TIMER;
      end else if (crystal) begin
        state_nxt = PURS_S_OST;
      end else begin
        state_nxt = PURS_S_RELEASE;
      end
      pc_load_nxt = 1'b1;
      st_val_nxt  = `PURS_ST_POR_VAL;
      st_msk_nxt  = `PURS_ST_POR_MSK;
    end else if (ext_evt) begin
      state_nxt   = PURS_S_RELEASE;
      pc_load_nxt = 1'b1;
      st_val_nxt  = sleep_active ? `PURS_ST_EXTSL_VAL : `PURS_ST_EXT_VAL;
      st_msk_nxt  = sleep_active ? `PURS_ST_EXTSL_MSK : `PURS_ST_EXT_MSK;
    end else if (wdt_rst_evt) begin
      state_nxt   = PURS_S_RELEASE;
      pc_load_nxt = 1'b1;
      st_val_nxt  = `PURS_ST_WDT_VAL;
      st_msk_nxt  = `PURS_ST_WDT_MSK;
    end else if (wdt_wake_evt || irq_wake_evt) begin
      state_nxt   = crystal ? PURS_S_OST : PURS_S_RUN;
      pc_load_nxt = irq_wake_evt && global_irq_enable;
      pc_vec_nxt  = `PURS_PC_IRQ_VEC;
      pc_adv_nxt  = !(irq_wake_evt && global_irq_enable);
      st_val_nxt  = irq_wake_evt ? `PURS_ST_IRQWK_VAL : `PURS_ST_WDTWK_VAL;
      st_msk_nxt  = irq_wake_evt ? `PURS_ST_IRQWK_MSK : `PURS_ST_WDTWK_MSK;
    end else begin
      st_load_nxt = 1'b0;
      case (state_r)
        PURS_S_STARTUP_DELAY_TIMER: begin
          if (startup_delay_timer_done) begin
            state_nxt = crystal ? PURS_S_OST : PURS_S_RELEASE;
          end
        end
        PURS_S_OST: begin
          if (ost_done) begin
            state_nxt = wake_ost_r ? PURS_S_RUN : PURS_S_RELEASE;
          end
        end
        PURS_S_RELEASE: begin
          if (ext_ok) begin
            state_nxt = PURS_S_RUN;
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
  end

  // ****************************************
  // state, release and outcome registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= PURS_S_POR;
      wake_ost_r <= 1'b0;
      core_reset <= 1'b1;
      core_hold  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      wake_ost_r <= wake_ost_nxt;
      core_reset <= (state_nxt != PURS_S_RUN) && !(state_nxt == PURS_S_OST && wake_ost_nxt);
      core_hold  <= (state_nxt == PURS_S_OST) && wake_ost_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_load            <= 1'b0;
      pc_vector          <= `PURS_PC_RESET_VEC;
      pc_advance         <= 1'b0;
      status_load        <= 1'b0;
      status_value       <= 8'h00;
      status_mask        <= 8'h00;
      irq_ctrl_flag_set  <= 3'h0;
      periph_flag_set    <= 1'b0;
      converter_go_clear <= 1'b0;
    end else begin
      pc_load            <= pc_load_nxt;
      pc_vector          <= pc_vec_nxt;
      pc_advance         <= pc_adv_nxt;
      status_load        <= st_load_nxt;
      status_value       <= st_val_nxt;
      status_mask        <= st_msk_nxt;
      irq_ctrl_flag_set  <= irq_wake_evt ? irq_wake_src[2:0] : 3'h0;
      periph_flag_set    <= irq_wake_evt && irq_wake_src[`PURS_SRC_ADC];
      converter_go_clear <= irq_wake_evt && irq_wake_src[`PURS_SRC_ADC];
    end
  end

  // ****************************************
  // register port
  // ****************************************
  logic       wr_pwr, wr_flags;
  logic [7:0] rd_nxt;

  assign wr_pwr   = reg_wr && (reg_addr == `PURS_ADDR_PWR_CTRL);
  assign wr_flags = reg_wr && (reg_addr == `PURS_ADDR_RST_FLAGS);

  // hardware causes win over a software write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_on_flag  <= 1'(`PURS_PWR_CTRL_RESET >> `PURS_BIT_POR_FLAG);
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
      reg_rdata      <= 8'h00;
    end else begin
      power_on_flag  <= por_evt ? 1'b0 : (wr_pwr ? reg_wdata[`PURS_BIT_POR_FLAG] : power_on_flag);
      timeout_flag   <= to_set ? 1'b1 : (to_clr ? 1'b0 :
                        (wr_flags ? reg_wdata[`PURS_BIT_TIMEOUT] : timeout_flag));
      powerdown_flag <= pd_set ? 1'b1 : (pd_clr ? 1'b0 :
                        (wr_flags ? reg_wdata[`PURS_BIT_POWERDOWN] : powerdown_flag));
      reg_rdata      <= rd_nxt;
    end
  end

  always_comb begin
    rd_nxt = 8'h00;
    if (reg_rd && reg_addr == `PURS_ADDR_PWR_CTRL) begin
      rd_nxt = {6'h00, power_on_flag, 1'b0};
    end else if (reg_rd && reg_addr == `PURS_ADDR_RST_FLAGS) begin
      rd_nxt = {1'b0, 3'(state_r), 2'h0, powerdown_flag, timeout_flag};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_por_taken;
    state_r == PURS_S_POR && sup2_r;
  endsequence

  property p_por_hold;
    @(posedge clk) disable iff (rst) (state_r == PURS_S_POR) |=> core_reset;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("core left reset before supply ok");

  property p_startup_delay_timer_len;
    @(posedge clk) disable iff (rst)
      (state_r == PURS_S_STARTUP_DELAY_TIMER && state_nxt != PURS_S_STARTUP_DELAY_TIMER && sup2_r) |-> startup_delay_timer_cnt_r == 17'(STARTUP_TICKS - 1);
  endproperty
  a_startup_delay_timer_len: assert property (p_startup_delay_timer_len) else $error("start-up delay ended early");

  property p_startup_delay_timer_hold;
    @(posedge clk) disable iff (rst) (state_r == PURS_S_STARTUP_DELAY_TIMER) |=> core_reset;
  endproperty
  a_startup_delay_timer_hold: assert property (p_startup_delay_timer_hold) else $error("reset dropped during start-up delay");

  property p_enable;
    @(posedge clk) disable iff (rst) s_por_taken ##0 !startup_delay_enable_n |=> state_r == PURS_S_STARTUP_DELAY_TIMER;
  endproperty
  a_enable: assert property (p_enable) else $error("start-up delay not applied");

  property p_ost_len;
    @(posedge clk) disable iff (rst)
      (state_r == PURS_S_OST && state_nxt != PURS_S_OST && sup2_r) |-> ost_cnt_r == 11'(OST_CYCLES - 1);
  endproperty
  a_ost_len: assert property (p_ost_len) else $error("stabilise count ended early");

  property p_ost_mode;
    @(posedge clk) disable iff (rst) (state_r != PURS_S_OST ##1 state_r == PURS_S_OST) |-> $past(crystal);
  endproperty
  a_ost_mode: assert property (p_ost_mode) else $error("stabilise count in rc mode");

  property p_por_flags;
    @(posedge clk) disable iff (rst) s_por_taken |=> !power_on_flag && timeout_flag && powerdown_flag;
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("power-on flags wrong");

  property p_ext_sleep;
    @(posedge clk) disable iff (rst) (ext_evt && sleep_active) |=> timeout_flag && !powerdown_flag;
  endproperty
  a_ext_sleep: assert property (p_ext_sleep) else $error("pin reset in sleep flags wrong");

  property p_irq_vec;
    @(posedge clk) disable iff (rst)
      (irq_wake_evt && global_irq_enable) |=> pc_load && pc_vector == `PURS_PC_IRQ_VEC && !pc_advance;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("irq wake vector wrong");

  property p_release;
    @(posedge clk) disable iff (rst) $fell(core_reset) |-> $past(ext_ok) && state_r == PURS_S_RUN;
  endproperty
  a_release: assert property (p_release) else $error("release while pin low");

endmodule // purs_seq

// ### purs_seq_tb.sv
// self-checking bench for the power-up reset sequencer
`timescale 1ns/100ps
`include "purs_defines.svh"

module purs_seq_tb import purs_pkg::*; ();
  // ****************************************
  // settings and signals
  // ****************************************
  // short counts keep the run brief; the start-up delay and stabilise bounds derive from them
  localparam int TICKS = 20;
  localparam int DIV   = 2;
  localparam int OSTC  = 8;
  localparam int PW    = TICKS * DIV;
  localparam int OL    = (OSTC - 1) * 70 / 20;

  typedef struct {purs_osc_mode_t m; logic en_n; int lo; int hi;} purs_row_t;

  logic                  clk, rst, supply_ok, external_reset_n, osc_input_pin, startup_delay_enable_n;
  logic                  sleep_active, wdt_expire, wake_irq, global_irq_enable, reg_wr, reg_rd;
  purs_osc_mode_t        osc_mode;
  logic [3:0]            irq_wake_src;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata, status_value, status_mask, cap_sv, cap_sm, rd_d;
  logic                  core_reset, core_hold, pc_load, pc_advance, status_load;
  logic [`PURS_PC_W-1:0] pc_vector, cap_pc;
  logic [2:0]            irq_ctrl_flag_set, cap_irq;
  logic                  periph_flag_set, converter_go_clear, timeout_flag, powerdown_flag, power_on_flag;
  logic                  cap_adv, cap_per, cap_cnv, cap_hold, cap_rst;
  int                    err_count, checks_done, n;
  purs_row_t             rows [5];

  purs_pin_model purs_pin_model_i (.supply_ok(supply_ok), .external_reset_n(external_reset_n),
    .osc_input_pin(osc_input_pin));

  purs_seq #(.STARTUP_TICKS(TICKS), .RC_DIV(DIV), .OST_CYCLES(OSTC)) purs_seq_i (
    .clk(clk), .rst(rst), .supply_ok(supply_ok), .external_reset_n(external_reset_n),
    .osc_input_pin(osc_input_pin), .startup_delay_enable_n(startup_delay_enable_n), .osc_mode(osc_mode),
    .sleep_active(sleep_active), .wdt_expire(wdt_expire), .wake_irq(wake_irq), .irq_wake_src(irq_wake_src),
    .global_irq_enable(global_irq_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_reset(core_reset), .core_hold(core_hold),
    .pc_load(pc_load), .pc_vector(pc_vector), .pc_advance(pc_advance), .status_load(status_load),
    .status_value(status_value), .status_mask(status_mask), .irq_ctrl_flag_set(irq_ctrl_flag_set),
    .periph_flag_set(periph_flag_set), .converter_go_clear(converter_go_clear),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .power_on_flag(power_on_flag));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // one-cycle outcome pulses are caught here so no pulse slips by
  always @(posedge clk) begin
    if (pc_load) cap_pc <= pc_vector;
    if (status_load) {cap_sv, cap_sm} <= {status_value, status_mask};
    if (|irq_ctrl_flag_set) cap_irq <= irq_ctrl_flag_set;
    cap_adv  <= cap_adv | pc_advance;
    cap_per  <= cap_per | periph_flag_set;
    cap_cnv  <= cap_cnv | converter_go_clear;
    cap_hold <= cap_hold | core_hold;
    cap_rst  <= cap_rst | core_reset;
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      err_count++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic outcome(input logic [15:0] st, input logic [15:0] fl);
    chk("status", st, {cap_sv, cap_sm});
    chk("flags", fl, 16'({power_on_flag, timeout_flag, powerdown_flag}));
  endtask

  // #1 keeps the clear away from the monitor's own edge update
  task automatic clr();
    #1;
    {cap_adv, cap_per, cap_cnv, cap_hold, cap_rst, cap_irq} = '0;
    cap_pc = '1;
    {cap_sv, cap_sm} = '1;
  endtask

  task automatic wait_low(ref logic s, output int k);
    k = 0;
    while (s !== 1'b0 && k < 400) begin
      @(posedge clk);
      k++;
    end
    if (k >= 400) begin
      err_count++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic ev(input logic w, input logic i);
    @(posedge clk);
    wdt_expire <= w;
    wake_irq   <= i;
    @(posedge clk);
    wdt_expire <= 1'b0;
    wake_irq   <= 1'b0;
  endtask

  task automatic boot(input purs_osc_mode_t m, input logic en_n);
    @(posedge clk);
    rst <= 1'b1;
    purs_pin_model_i.power(1'b0);
    osc_mode               <= m;
    startup_delay_enable_n <= en_n;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk("held without supply", 16'h1, 16'(core_reset));
    purs_pin_model_i.power(1'b1);
  endtask

  task automatic pin_low(input int k);
    @(posedge clk);
    purs_pin_model_i.pin(1'b0);
    repeat (k) @(posedge clk);
    purs_pin_model_i.pin(1'b1);
  endtask

  task automatic wake(input logic w, input logic g, input logic [3:0] src);
    clr();
    @(posedge clk);
    sleep_active      <= 1'b1;
    global_irq_enable <= g;
    irq_wake_src      <= src;
    ev(w, ~w);
    repeat (2) @(posedge clk);
    wait_low(core_hold, n);
    chk("hold seen", 16'h1, 16'(cap_hold));
    chk_rng("hold cycles", OL - 3, OL + 24, n);
    sleep_active <= 1'b0;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, wdt_expire, wake_irq, sleep_active, global_irq_enable, startup_delay_enable_n} = '0;
    {reg_addr, reg_wdata, irq_wake_src} = '0;
    osc_mode = PURS_INTERNAL_RC;
    err_count = 0;
    checks_done = 0;
    rows = '{'{PURS_INTERNAL_RC, 1'b1, 0, 20}, '{PURS_EXTERNAL_RC, 1'b0, PW, PW + 20},
             '{PURS_LOW_POWER_CRYSTAL, 1'b1, OL, OL + 24}, '{PURS_STANDARD_CRYSTAL, 1'b0, PW + OL, PW + OL + 24},
             '{PURS_FAST_CRYSTAL, 1'b0, PW + OL, PW + OL + 24}};
    foreach (rows[i]) begin
      clr();
      boot(rows[i].m, rows[i].en_n);
      wait_low(core_reset, n);
      chk_rng("release cycles", rows[i].lo, rows[i].hi, n);
      chk("pc", 16'h0000, 16'(cap_pc));
      outcome(16'h18F8, 16'h0003);
      $display("power-up row %0d done", i);
    end
    wr(`PURS_ADDR_PWR_CTRL, 8'hFF);
    rd(`PURS_ADDR_PWR_CTRL, rd_d);
    chk("power control", 16'h0002, 16'(rd_d));
    rd(`PURS_ADDR_RST_FLAGS, rd_d);
    chk("cause register", 16'h0043, 16'(rd_d));
    rd(8'h10, rd_d);
    chk("unmapped read", 16'h0000, 16'(rd_d));
    $display("register test done");
    clr();
    pin_low(3);
    repeat (20) @(posedge clk);
    chk("glitch reset", 16'h0, 16'(cap_rst));
    clr();
    pin_low(40);
    wait_low(core_reset, n);
    chk("pin reset seen", 16'h1, 16'(cap_rst));
    chk_rng("pin release", 0, 20, n);
    chk("pin pc", 16'h0000, 16'(cap_pc));
    outcome(16'h00E0, 16'h0007);
    $display("pin tests done");
    clr();
    ev(1'b1, 1'b0);
    repeat (2) @(posedge clk);
    wait_low(core_reset, n);
    chk("watchdog reset seen", 16'h1, 16'(cap_rst));
    chk("watchdog pc", 16'h0000, 16'(cap_pc));
    outcome(16'h00F0, 16'h0005);
    $display("watchdog reset done");
    wake(1'b0, 1'b1, 4'h9);
    chk("irq pc", 16'h0004, 16'(cap_pc));
    outcome(16'h1018, 16'h0006);
    chk("wake bits", 16'h0019, 16'({cap_per, cap_cnv, cap_irq}));
    wake(1'b0, 1'b0, 4'h2);
    chk("irq advance", 16'h1, 16'(cap_adv));
    chk("wake bits", 16'h0002, 16'({cap_per, cap_cnv, cap_irq}));
    wake(1'b1, 1'b0, 4'h0);
    chk("watchdog advance", 16'h1, 16'(cap_adv));
    outcome(16'h0018, 16'h0004);
    $display("wake tests done");
    // supply dip after a wake re-fires the power-on detector, straight into the stabilise count with no core hold
    clr();
    @(posedge clk);
    startup_delay_enable_n <= 1'b1;
    purs_pin_model_i.power(1'b0);
    repeat (20) @(posedge clk);
    purs_pin_model_i.power(1'b1);
    wait_low(core_reset, n);
    chk_rng("dip release", OL, OL + 24, n);
    chk("dip hold", 16'h0, 16'(cap_hold));
    outcome(16'h18F8, 16'h0003);
    $display("supply dip test done");
    clr();
    @(posedge clk);
    sleep_active <= 1'b1;
    pin_low(40);
    wait_low(core_reset, n);
    sleep_active <= 1'b0;
    chk_rng("sleep pin release", 0, 20, n);
    chk("sleep pin pc", 16'h0000, 16'(cap_pc));
    outcome(16'h10F8, 16'h0002);
    $display("sleep pin test done");
    // timers keep running while the pin is held low
    purs_pin_model_i.pin(1'b0);
    boot(PURS_FAST_CRYSTAL, 1'b0);
    repeat (PW + OL + 40) @(posedge clk);
    chk("held by pin", 16'h1, 16'(core_reset));
    purs_pin_model_i.pin(1'b1);
    wait_low(core_reset, n);
    chk_rng("late pin release", 0, 20, n);
    $display("late pin test done");
    give_verdict();
  end
endmodule // purs_seq_tb
